// *** include/wit_defs.svh ***
`ifndef WIT_DEFS_SVH
`define WIT_DEFS_SVH
// Summary of operation
// RULE1: Per-pin edge select: falling, rising, both, off
// RULE2: Enabled edge in Standby/Normal raises wake interrupt
// RULE3: Enabled wake edge in Sleep enters Standby
// RULE4: Level status only when some pin enabled
// RULE5: Pin sampled continuously, or on bias strobe
// RULE6: Strobed sampling captures at strobe rising edge
// RULE7: Strobe period 16 ms or 64 ms by bit
// RULE8: Interrupt pin active low, open drain, pending-driven
// RULE9: Host clears flags by writing ones only
// RULE10: Clearing LIN wake flag keeps pending wake
// RULE11: Pending LIN wake clears in Normal, standby-control low
// RULE12: Cyclic interrupt enabled entering watchdog Timeout mode
// RULE13: Watchdog overflow in Timeout sets cyclic flag
// RULE14: Overtemperature in Normal/Standby enters Overtemp mode
// RULE15: Overtemp holds reset low, limp-home active
// RULE16: Overtemp switches off regulator and LIN transmitter
// RULE17: Overtemperature gone: Overtemp returns to Standby
// RULE18: Mode field: 00 Standby, 01 Sleep, 1x Normal
// RULE19: Limp-home control forced set during Overtemp
// RULE20: Interrupt flags stay set until host clears
// RULE21: Wake pins synchronised, one event per edge

// ==========================================
// Register offsets (byte addresses)
`define WIT_OFF_CTRL 12'h000
`define WIT_OFF_INT 12'h004
`define WIT_OFF_STAT 12'h008

// ==========================================
// Control register fields
`define WIT_CTL_MODE 0
`define WIT_CTL_CFGA 2
`define WIT_CTL_CFGB 4
`define WIT_CTL_SSEA 6
`define WIT_CTL_SSEB 7
`define WIT_CTL_BSEL 8
`define WIT_CTL_LSTB 9
`define WIT_CTL_LIMP 10

// ==========================================
// Interrupt status fields (write 1 to clear)
`define WIT_INT_WAKEA 0
`define WIT_INT_WAKEB 1
`define WIT_INT_LWI 2
`define WIT_INT_CI 3

// ==========================================
// Status register fields
`define WIT_ST_LVLA 0
`define WIT_ST_LVLB 1
`define WIT_ST_MODE 2
`define WIT_ST_LPEND 4
`define WIT_ST_CIEN 5
`define WIT_ST_IRQPIN 6

// ==========================================
// Codes and reset values
`define WIT_MC_STANDBY 2'b00
`define WIT_MC_SLEEP 2'b01
`define WIT_EDGE_OFF 2'b00
`define WIT_EDGE_FALL 2'b01
`define WIT_EDGE_RISE 2'b10
`define WIT_EDGE_BOTH 2'b11
`define WIT_MODE_RST 2'b00
`define WIT_CFG_RST 2'b00

// ==========================================
// Timing
`define WIT_CLK_KHZ 200000
`define WIT_BIAS_SHORT_MS 16
`define WIT_BIAS_LONG_MS 64
`define WIT_BIAS_ON_NS 1000
`define WIT_CLK_NS 5
`define WIT_BIAS_CNT_W 24
`endif

// *** include/wit_pkg.sv ***
`include "wit_defs.svh"
package wit_pkg;
    // Operating modes, Gray along standby-normal-overtemp-sleep
    typedef enum logic [1:0] {
        wit_standby = 2'b00,
        wit_normal = 2'b01,
        wit_overtemp = 2'b11,
        wit_sleep = 2'b10
    } wit_mode_e;

    // Configuration of one wake pin
    typedef struct packed {
        logic [1:0] edge_cfg;
        logic strobe_en;
    } wit_wake_cfg_s;

    // State of one wake channel
    typedef struct packed {
        logic sync1;
        logic sync2;
        logic sampled;
        logic primed;
        logic evt;
    } wit_chan_s;

    // State of the controller
    typedef struct packed {
        logic [1:0] op_mode_field;
        wit_wake_cfg_s cfg_a;
        wit_wake_cfg_s cfg_b;
        logic wake_bias_period_sel;
        logic lin_standby_ctrl;
        logic limp_home_ctrl;
        logic [3:0] int_flags;
        logic lin_pending;
        logic ci_en;
        logic wd_tmo_prev;
        wit_mode_e mode;
        logic [`WIT_BIAS_CNT_W-1:0] bias_cnt;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic irq_out_n;
        logic irq_oe_n;
        logic system_reset_out_n;
        logic limp_home_out_n;
        logic v1_reg_en;
        logic lin_tx_en;
        logic wake_bias_strobe_out;
    } wit_state_s;
endpackage

// *** logic/wit_wake_chan.sv ***
`timescale 1ns/1ps
`include "wit_defs.svh"
module wit_wake_chan (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // Pin and configuration
    input wire logic pin,
    input wire wit_pkg::wit_wake_cfg_s cfg,
    input wire logic strobe_rise,
    // Results
    output logic level,
    output logic evt
);
    wit_pkg::wit_chan_s q;
    wit_pkg::wit_chan_s d;
    logic rise;
    logic fall;

    // ==========================================
    // Sync, sample and edge detect
    always_comb begin
        d = q;
        d.sync1 = pin;
        d.sync2 = q.sync1; // see RULE21
        if (!cfg.strobe_en || strobe_rise) begin // see RULE5
            d.sampled = q.sync2; // see RULE6
            d.primed = 1'b1;
        end
        // No edge on the very first sample after reset
        rise = d.sampled & ~q.sampled & q.primed;
        fall = ~d.sampled & q.sampled & q.primed;
        d.evt = (cfg.edge_cfg[1] & rise) | (cfg.edge_cfg[0] & fall); // see RULE1
    end

    // Register, frozen while clk_en is low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
        end else if (clk_en) begin
            q <= d;
        end
    end

    assign level = q.sampled;
    assign evt = q.evt;

    // ==========================================
    // Checks
    property p_off_no_evt;
        @(posedge pclk) disable iff (!presetn)
        clk_en && cfg.edge_cfg == `WIT_EDGE_OFF |=> !evt;
    endproperty
    a_off_no_evt: assert property (p_off_no_evt) else $error("wake event while pin disabled"); // see RULE1

    property p_strobe_hold;
        @(posedge pclk) disable iff (!presetn)
        clk_en && cfg.strobe_en && !strobe_rise |=> $stable(q.sampled);
    endproperty
    a_strobe_hold: assert property (p_strobe_hold) else $error("sample moved between strobes"); // see RULE6
endmodule

// *** logic/wit_top.sv ***
// The register addresses and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "wit_defs.svh"
module wit_top #(
    parameter int BIAS_SHORT_CYC = `WIT_BIAS_SHORT_MS * `WIT_CLK_KHZ,
    parameter int BIAS_LONG_CYC = `WIT_BIAS_LONG_MS * `WIT_CLK_KHZ,
    parameter int BIAS_ON_CYC = `WIT_BIAS_ON_NS / `WIT_CLK_NS
) (
    // Clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic pslverr,
    output logic [31:0] prdata,
    // Wake pins and bias strobe
    input wire logic local_wake_pin_a,
    input wire logic local_wake_pin_b,
    output logic wake_bias_strobe_out,
    // LIN wake and watchdog
    input wire logic lin_wake_evt,
    input wire logic wd_timeout_mode,
    input wire logic wd_overflow,
    input wire logic watchdog_disable_pin,
    // Temperature
    input wire logic overtemp_ind,
    // Interrupt pin, open drain
    input wire logic irq_in_n,
    output logic irq_out_n,
    output logic irq_oe_n,
    // System outputs
    output logic system_reset_out_n,
    output logic limp_home_out_n,
    output logic v1_reg_en,
    output logic lin_tx_en
);
    localparam int CW = `WIT_BIAS_CNT_W;
    localparam logic [CW-1:0] SHORT_LAST = CW'(BIAS_SHORT_CYC - 1);
    localparam logic [CW-1:0] LONG_LAST = CW'(BIAS_LONG_CYC - 1);
    localparam logic [CW-1:0] ON_CYC = CW'(BIAS_ON_CYC);
    localparam wit_pkg::wit_state_s STATE_RST = '{
        op_mode_field: `WIT_MODE_RST,
        cfg_a: '{edge_cfg: `WIT_CFG_RST, strobe_en: 1'b0},
        cfg_b: '{edge_cfg: `WIT_CFG_RST, strobe_en: 1'b0},
        mode: wit_pkg::wit_standby,
        irq_oe_n: 1'b1,
        limp_home_out_n: 1'b1,
        default: '0
    };

    wit_pkg::wit_state_s q;
    wit_pkg::wit_state_s d;
    logic lvl_a;
    logic lvl_b;
    logic evt_a;
    logic evt_b;
    logic strobe_rise;

    // ==========================================
    // Wake channels
    assign strobe_rise = (q.bias_cnt == '0);

    wit_wake_chan u_chan_a (
        .pclk(pclk),
        .presetn(presetn),
        .clk_en(clk_en),
        .pin(local_wake_pin_a),
        .cfg(q.cfg_a),
        .strobe_rise(strobe_rise),
        .level(lvl_a),
        .evt(evt_a)
    );

    wit_wake_chan u_chan_b (
        .pclk(pclk),
        .presetn(presetn),
        .clk_en(clk_en),
        .pin(local_wake_pin_b),
        .cfg(q.cfg_b),
        .strobe_rise(strobe_rise),
        .level(lvl_b),
        .evt(evt_b)
    );

    // ==========================================
    // Next-state logic
    always_comb begin
        logic access;
        logic commit;
        logic hit;
        logic active;
        logic any_en;
        logic lin_wake;
        logic wake_any;
        logic [CW-1:0] last;
        logic [31:0] stat;
        access = 1'b0;
        commit = 1'b0;
        hit = 1'b0;
        active = 1'b0;
        any_en = 1'b0;
        lin_wake = 1'b0;
        wake_any = 1'b0;
        last = '0;
        stat = '0;
        // Flags hold until a host write clears them
        d = q; // see RULE20

        // Bus decode; a write lands at the edge that sees pready
        access = psel & penable & ~q.pready;
        commit = psel & penable & q.pready;
        hit = (paddr == `WIT_OFF_CTRL) || (paddr == `WIT_OFF_INT) || (paddr == `WIT_OFF_STAT);
        d.pready = access;
        d.pslverr = access & ~hit;
        active = (q.mode == wit_pkg::wit_standby) || (q.mode == wit_pkg::wit_normal);

        // Control register write
        if (commit && pwrite && paddr == `WIT_OFF_CTRL) begin
            d.op_mode_field = pwdata[`WIT_CTL_MODE +: 2];
            d.cfg_a.edge_cfg = pwdata[`WIT_CTL_CFGA +: 2]; // see RULE1
            d.cfg_b.edge_cfg = pwdata[`WIT_CTL_CFGB +: 2]; // see RULE1
            d.cfg_a.strobe_en = pwdata[`WIT_CTL_SSEA];
            d.cfg_b.strobe_en = pwdata[`WIT_CTL_SSEB];
            d.wake_bias_period_sel = pwdata[`WIT_CTL_BSEL];
            d.lin_standby_ctrl = pwdata[`WIT_CTL_LSTB];
            d.limp_home_ctrl = pwdata[`WIT_CTL_LIMP];
        end

        // Bias strobe; shortening the period mid-count just wraps early
        last = q.wake_bias_period_sel ? LONG_LAST : SHORT_LAST; // see RULE7
        if (q.bias_cnt >= last) begin
            d.bias_cnt = '0;
        end else begin
            d.bias_cnt = q.bias_cnt + CW'(1);
        end
        d.wake_bias_strobe_out = (d.bias_cnt < ON_CYC);

        // Write-one-to-clear first, so a same-cycle set wins
        if (commit && pwrite && paddr == `WIT_OFF_INT) begin
            d.int_flags = q.int_flags & ~pwdata[3:0]; // see RULE9
        end

        // Local wake interrupts
        if (active && evt_a) begin
            d.int_flags[`WIT_INT_WAKEA] = 1'b1; // see RULE2
        end
        if (active && evt_b) begin
            d.int_flags[`WIT_INT_WAKEB] = 1'b1; // see RULE2
        end

        // LIN wake: flag and pending condition are separate
        if (q.mode == wit_pkg::wit_normal && !q.lin_standby_ctrl) begin
            d.lin_pending = 1'b0; // see RULE11
        end
        lin_wake = lin_wake_evt & q.lin_standby_ctrl;
        if (lin_wake) begin
            d.lin_pending = 1'b1; // see RULE10
            d.int_flags[`WIT_INT_LWI] = 1'b1;
        end

        // Cyclic interrupt enable follows watchdog Timeout entry
        d.wd_tmo_prev = wd_timeout_mode;
        if (!wd_timeout_mode) begin
            d.ci_en = 1'b0;
        end else if (!q.wd_tmo_prev && active && !watchdog_disable_pin) begin
            d.ci_en = 1'b1; // see RULE12
        end
        if (wd_overflow && wd_timeout_mode && q.ci_en) begin
            d.int_flags[`WIT_INT_CI] = 1'b1; // see RULE13
        end

        // Mode sequencing
        wake_any = evt_a | evt_b | lin_wake;
        unique case (q.mode)
            wit_pkg::wit_standby, wit_pkg::wit_normal: begin
                if (overtemp_ind) begin
                    d.mode = wit_pkg::wit_overtemp; // see RULE14
                end else if (d.op_mode_field == `WIT_MC_STANDBY) begin
                    d.mode = wit_pkg::wit_standby; // see RULE18
                end else if (d.op_mode_field == `WIT_MC_SLEEP) begin
                    d.mode = wit_pkg::wit_sleep;
                end else begin
                    d.mode = wit_pkg::wit_normal;
                end
            end
            wit_pkg::wit_sleep: begin
                if (wake_any || d.op_mode_field == `WIT_MC_STANDBY) begin
                    d.mode = wit_pkg::wit_standby; // see RULE3
                    d.op_mode_field = `WIT_MC_STANDBY;
                end else if (d.op_mode_field[1]) begin
                    d.mode = wit_pkg::wit_normal;
                end
            end
            wit_pkg::wit_overtemp: begin
                if (!overtemp_ind) begin
                    d.mode = wit_pkg::wit_standby; // see RULE17
                    d.op_mode_field = `WIT_MC_STANDBY;
                end
            end
        endcase
        if (d.mode == wit_pkg::wit_overtemp) begin
            d.limp_home_ctrl = 1'b1; // see RULE19
        end

        // Registered pin outputs, taken from the next state
        d.irq_out_n = 1'b0;
        d.irq_oe_n = ~(|d.int_flags); // see RULE8
        d.system_reset_out_n = (d.mode != wit_pkg::wit_overtemp); // see RULE15
        d.limp_home_out_n = ~d.limp_home_ctrl; // see RULE15
        d.v1_reg_en = (d.mode != wit_pkg::wit_overtemp) && (d.mode != wit_pkg::wit_sleep); // see RULE16
        d.lin_tx_en = (d.mode == wit_pkg::wit_normal) && !d.lin_standby_ctrl; // see RULE16

        // Read data, latched with pready
        any_en = (q.cfg_a.edge_cfg != `WIT_EDGE_OFF) || (q.cfg_b.edge_cfg != `WIT_EDGE_OFF);
        stat[`WIT_ST_LVLA] = lvl_a & any_en; // see RULE4
        stat[`WIT_ST_LVLB] = lvl_b & any_en; // see RULE4
        stat[`WIT_ST_MODE +: 2] = q.mode;
        stat[`WIT_ST_LPEND] = q.lin_pending;
        stat[`WIT_ST_CIEN] = q.ci_en;
        stat[`WIT_ST_IRQPIN] = irq_in_n;
        if (access && !pwrite) begin
            unique case (paddr)
                `WIT_OFF_CTRL: begin
                    d.prdata = '0;
                    d.prdata[`WIT_CTL_MODE +: 2] = q.op_mode_field;
                    d.prdata[`WIT_CTL_CFGA +: 2] = q.cfg_a.edge_cfg;
                    d.prdata[`WIT_CTL_CFGB +: 2] = q.cfg_b.edge_cfg;
                    d.prdata[`WIT_CTL_SSEA] = q.cfg_a.strobe_en;
                    d.prdata[`WIT_CTL_SSEB] = q.cfg_b.strobe_en;
                    d.prdata[`WIT_CTL_BSEL] = q.wake_bias_period_sel;
                    d.prdata[`WIT_CTL_LSTB] = q.lin_standby_ctrl;
                    d.prdata[`WIT_CTL_LIMP] = q.limp_home_ctrl;
                end
                `WIT_OFF_INT: begin
                    d.prdata = {28'h0000000, q.int_flags};
                end
                `WIT_OFF_STAT: begin
                    d.prdata = stat;
                end
                default: begin
                    d.prdata = '0;
                end
            endcase
        end
    end

    // ==========================================
    // State register, frozen while clk_en is low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= STATE_RST;
        end else if (clk_en) begin
            q <= d;
        end
    end

    assign pready = q.pready;
    assign pslverr = q.pslverr;
    assign prdata = q.prdata;
    assign wake_bias_strobe_out = q.wake_bias_strobe_out;
    assign irq_out_n = q.irq_out_n;
    assign irq_oe_n = q.irq_oe_n;
    assign system_reset_out_n = q.system_reset_out_n;
    assign limp_home_out_n = q.limp_home_out_n;
    assign v1_reg_en = q.v1_reg_en;
    assign lin_tx_en = q.lin_tx_en;

    // ==========================================
    // Checks
    property p_irq_pin;
        @(posedge pclk) disable iff (!presetn)
        irq_oe_n == !(|q.int_flags);
    endproperty
    a_irq_pin: assert property (p_irq_pin) else $error("interrupt pin disagrees with flags"); // see RULE8

    property p_w1c_keep;
        @(posedge pclk) disable iff (!presetn)
        clk_en && psel && penable && pready && pwrite && paddr == `WIT_OFF_INT
            && !pwdata[`WIT_INT_CI] && q.int_flags[`WIT_INT_CI] |=> q.int_flags[`WIT_INT_CI];
    endproperty
    a_w1c_keep: assert property (p_w1c_keep) else $error("flag cleared without a one written"); // see RULE9

    property p_wake_irq;
        @(posedge pclk) disable iff (!presetn)
        clk_en && evt_a && (q.mode == wit_pkg::wit_standby || q.mode == wit_pkg::wit_normal)
            |=> q.int_flags[`WIT_INT_WAKEA];
    endproperty
    a_wake_irq: assert property (p_wake_irq) else $error("wake edge raised no interrupt"); // see RULE2

    property p_sleep_wake;
        @(posedge pclk) disable iff (!presetn)
        clk_en && q.mode == wit_pkg::wit_sleep && (evt_a || evt_b) |=> q.mode == wit_pkg::wit_standby;
    endproperty
    a_sleep_wake: assert property (p_sleep_wake) else $error("wake in sleep did not reach standby"); // see RULE3

    property p_lin_clear;
        @(posedge pclk) disable iff (!presetn)
        clk_en && q.mode == wit_pkg::wit_normal && !q.lin_standby_ctrl && !lin_wake_evt |=> !q.lin_pending;
    endproperty
    a_lin_clear: assert property (p_lin_clear) else $error("LIN wake pending not cleared"); // see RULE11

    property p_ci_set;
        @(posedge pclk) disable iff (!presetn)
        clk_en && q.ci_en && wd_timeout_mode && wd_overflow |=> q.int_flags[`WIT_INT_CI] && !irq_oe_n;
    endproperty
    a_ci_set: assert property (p_ci_set) else $error("overflow raised no cyclic interrupt"); // see RULE13

    property p_ot_enter;
        @(posedge pclk) disable iff (!presetn)
        clk_en && overtemp_ind && (q.mode == wit_pkg::wit_standby || q.mode == wit_pkg::wit_normal)
            |=> q.mode == wit_pkg::wit_overtemp;
    endproperty
    a_ot_enter: assert property (p_ot_enter) else $error("overtemperature ignored"); // see RULE14

    property p_ot_pins;
        @(posedge pclk) disable iff (!presetn)
        q.mode == wit_pkg::wit_overtemp |-> !system_reset_out_n && !limp_home_out_n && q.limp_home_ctrl;
    endproperty
    a_ot_pins: assert property (p_ot_pins) else $error("overtemp reset or limp not active"); // see RULE15

    property p_ot_off;
        @(posedge pclk) disable iff (!presetn)
        q.mode == wit_pkg::wit_overtemp |-> !v1_reg_en && !lin_tx_en;
    endproperty
    a_ot_off: assert property (p_ot_off) else $error("overtemp left regulator or LIN on"); // see RULE16

    property p_ot_exit;
        @(posedge pclk) disable iff (!presetn)
        clk_en && q.mode == wit_pkg::wit_overtemp && !overtemp_ind |=> q.mode == wit_pkg::wit_standby;
    endproperty
    a_ot_exit: assert property (p_ot_exit) else $error("overtemp did not return to standby"); // see RULE17

    property p_flag_sticky;
        @(posedge pclk) disable iff (!presetn)
        clk_en && q.int_flags[`WIT_INT_WAKEA] && !(psel && penable && pready && pwrite)
            |=> q.int_flags[`WIT_INT_WAKEA];
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped without host write"); // see RULE20
endmodule

// *** testbench/wit_host.sv ***
`timescale 1ns/1ps
module wit_host (
    // Clock
    input wire logic pclk,
    // APB master side
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [31:0] prdata,
    // Interrupt wire
    input wire logic irq_out_n,
    input wire logic irq_oe_n,
    output logic irq_in_n
);
    logic err = 1'b0;
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
    end
    // Pull-up wins only while nobody pulls low
    assign irq_in_n = irq_oe_n ? 1'b1 : irq_out_n;
    // One transfer; held until pready is sampled, so slow answers are fine
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule

// *** testbench/tb_top.sv ***
`timescale 1ns/1ps
`include "wit_defs.svh"
module tb_top;
    // ==========================================
    // Signals
    localparam int SHORT = 40;
    localparam int LONG = 160;
    localparam int ON = 4;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic clk_en = 1'b1;
    logic psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [31:0] seed = 32'haac51b85;
    logic local_wake_pin_a = 1'b0;
    logic local_wake_pin_b = 1'b0;
    logic lin_wake_evt = 1'b0;
    logic wd_timeout_mode = 1'b0;
    logic wd_overflow = 1'b0;
    logic watchdog_disable_pin = 1'b0;
    logic overtemp_ind = 1'b0;
    logic wake_bias_strobe_out, irq_in_n, irq_out_n, irq_oe_n;
    logic system_reset_out_n, limp_home_out_n, v1_reg_en, lin_tx_en;
    int fails = 0;
    int num_checks = 0;
    int m_int = 0;
    // Short strobe counts keep the run brief
    wit_top #(.BIAS_SHORT_CYC(SHORT), .BIAS_LONG_CYC(LONG), .BIAS_ON_CYC(ON)) i_dut (
        .pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .prdata,
        .local_wake_pin_a, .local_wake_pin_b, .wake_bias_strobe_out, .lin_wake_evt, .wd_timeout_mode,
        .wd_overflow, .watchdog_disable_pin, .overtemp_ind, .irq_in_n, .irq_out_n, .irq_oe_n,
        .system_reset_out_n, .limp_home_out_n, .v1_reg_en, .lin_tx_en
    );
    wit_host i_host (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .prdata,
        .irq_out_n, .irq_oe_n, .irq_in_n);
    always #2.5 pclk = ~pclk;
    // ==========================================
    // Helpers
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        i_host.xfer(1'b1, a, d, q);
    endtask
    task automatic rc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
        i_host.xfer(1'b0, a, 32'h0, q);
        chk(q & m, e);
    endtask
    // Strobe high time and period, counted from a low phase
    task automatic per(input int p);
        int hi = 0;
        int n = 0;
        while (wake_bias_strobe_out !== 1'b0) @(posedge pclk);
        while (wake_bias_strobe_out !== 1'b1) @(posedge pclk);
        while (wake_bias_strobe_out === 1'b1) begin
            @(posedge pclk);
            hi++;
        end
        while (wake_bias_strobe_out !== 1'b1) begin
            @(posedge pclk);
            n++;
        end
        chk(32'(hi), 32'(ON));
        chk(32'(hi + n), 32'(p));
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // Watchdog against a hang
    initial begin
        #200000;
        fails++;
        end_sim();
    end
    // ==========================================
    // Tests
    initial begin
        cyc(4);
        presetn <= 1'b1;
        local_wake_pin_a <= 1'b1;
        cyc(6);
        chk({26'h0, v1_reg_en, system_reset_out_n, limp_home_out_n, lin_tx_en, irq_oe_n, irq_out_n}, 32'h3a);
        rc(`WIT_OFF_CTRL, 32'hffffffff, 32'h0);
        rc(`WIT_OFF_STAT, 32'hffffffff, 32'h40);
        rc(12'h00c, 32'hffffffff, 32'h0);
        chk({31'h0, i_host.err}, 32'h1);
        local_wake_pin_a <= 1'b0;
        $display("test reset done");
        // Every edge code on pin A, random levels on pin B with both edges
        for (int c = 0; c < 4; c++) begin
            wr(`WIT_OFF_INT, 32'hf);
            m_int = 0;
            wr(`WIT_OFF_CTRL, 32'h30 | 32'(c << 2));
            for (int k = 0; k < 2; k++) begin
                q = xs();
                if (q[0] !== local_wake_pin_b) m_int = m_int | 2;
                if (c[1 - k]) m_int = m_int | 1;
                local_wake_pin_b <= q[0];
                local_wake_pin_a <= ~local_wake_pin_a;
                cyc(8);
                rc(`WIT_OFF_INT, 32'hf, 32'(m_int));
                chk({31'h0, irq_oe_n}, {31'h0, m_int == 0});
                rc(`WIT_OFF_STAT, 32'h3, {30'h0, local_wake_pin_b, local_wake_pin_a});
            end
        end
        wr(`WIT_OFF_INT, 32'h2);
        rc(`WIT_OFF_INT, 32'hf, 32'(m_int & 1));
        $display("test edges done");
        // Strobed sampling ignores a pulse between strobes
        wr(`WIT_OFF_INT, 32'hf);
        wr(`WIT_OFF_CTRL, 32'h48);
        per(SHORT);
        cyc(3);
        local_wake_pin_a <= 1'b1;
        cyc(10);
        local_wake_pin_a <= 1'b0;
        cyc(SHORT);
        rc(`WIT_OFF_INT, 32'hf, 32'h0);
        local_wake_pin_a <= 1'b1;
        cyc(SHORT + 8);
        rc(`WIT_OFF_INT, 32'hf, 32'h1);
        wr(`WIT_OFF_CTRL, 32'h148);
        per(LONG);
        $display("test strobe done");
        // LIN wake: flag and pending condition clear separately
        wr(`WIT_OFF_INT, 32'hf);
        wr(`WIT_OFF_CTRL, 32'h200);
        local_wake_pin_a <= 1'b0;
        lin_wake_evt <= 1'b1;
        cyc(1);
        lin_wake_evt <= 1'b0;
        cyc(4);
        rc(`WIT_OFF_INT, 32'hf, 32'h4);
        wr(`WIT_OFF_INT, 32'h4);
        rc(`WIT_OFF_INT, 32'hf, 32'h0);
        rc(`WIT_OFF_STAT, 32'h10, 32'h10);
        wr(`WIT_OFF_CTRL, 32'h3);
        cyc(2);
        rc(`WIT_OFF_STAT, 32'h3c, 32'h4);
        chk({31'h0, lin_tx_en}, 32'h1);
        $display("test lin done");
        // Overtemp from Normal, then back to Standby
        overtemp_ind <= 1'b1;
        cyc(3);
        chk({28'h0, system_reset_out_n, limp_home_out_n, v1_reg_en, lin_tx_en}, 32'h0);
        rc(`WIT_OFF_STAT, 32'hc, 32'hc);
        rc(`WIT_OFF_CTRL, 32'h400, 32'h400);
        overtemp_ind <= 1'b0;
        cyc(3);
        rc(`WIT_OFF_STAT, 32'hc, 32'h0);
        chk({30'h0, system_reset_out_n, v1_reg_en}, 32'h3);
        wr(`WIT_OFF_CTRL, 32'hd);
        cyc(2);
        chk({30'h0, limp_home_out_n, v1_reg_en}, 32'h2);
        // Sleep: temperature not watched, wake edge leaves for Standby
        overtemp_ind <= 1'b1;
        cyc(3);
        rc(`WIT_OFF_STAT, 32'hc, 32'h8);
        overtemp_ind <= 1'b0;
        local_wake_pin_a <= 1'b1;
        cyc(8);
        rc(`WIT_OFF_STAT, 32'hc, 32'h0);
        rc(`WIT_OFF_CTRL, 32'h3, 32'h0);
        $display("test modes done");
        // Cyclic interrupt, blocked then enabled
        watchdog_disable_pin <= 1'b1;
        wd_timeout_mode <= 1'b1;
        cyc(3);
        rc(`WIT_OFF_STAT, 32'h20, 32'h0);
        wd_timeout_mode <= 1'b0;
        watchdog_disable_pin <= 1'b0;
        cyc(2);
        wd_timeout_mode <= 1'b1;
        cyc(3);
        rc(`WIT_OFF_STAT, 32'h20, 32'h20);
        for (int k = 0; k < 2; k++) begin
            wr(`WIT_OFF_INT, 32'hf);
            wd_overflow <= 1'b1;
            cyc(1);
            wd_overflow <= 1'b0;
            cyc(3);
            rc(`WIT_OFF_INT, 32'hf, 32'h8);
            rc(`WIT_OFF_STAT, 32'h40, 32'h0);
        end
        // Overflow pulse while clk_en is low must be missed
        wr(`WIT_OFF_INT, 32'hf);
        clk_en <= 1'b0;
        wd_overflow <= 1'b1;
        cyc(2);
        wd_overflow <= 1'b0;
        clk_en <= 1'b1;
        cyc(2);
        rc(`WIT_OFF_INT, 32'hf, 32'h0);
        $display("test cyclic done");
        end_sim();
    end
endmodule
